// ===== eta_pkg.sv
// constants, register map and control field layouts for the event timer array
package eta_pkg;
  localparam int CNT_W     = 16;
  localparam int NUM_CAP   = 10;
  localparam int NUM_CH    = 12;
  localparam int NUM_TMR   = 2;
  localparam int ADDR_W    = 8;

  // byte addresses, one 32-bit word each
  localparam logic [7:0] ADR_TMR_CTL0  = 8'h00;
  localparam logic [7:0] ADR_TMR_CTL1  = 8'h04;
  localparam logic [7:0] ADR_TMR_VAL0  = 8'h08;
  localparam logic [7:0] ADR_TMR_VAL1  = 8'h0C;
  localparam logic [7:0] ADR_PEND      = 8'h10;
  localparam logic [7:0] ADR_OVR_PEND  = 8'h14;
  localparam logic [7:0] ADR_OVR_MASK  = 8'h18;
  localparam logic [7:0] ADR_CH_CTL    = 8'h40;
  localparam logic [7:0] ADR_CH_TIME   = 8'h80;
  localparam logic [7:0] ADR_BLK_MASK  = 8'hC0;

  // pending word: channel events in 11:0, counter overflows in 13:12
  localparam int PEND_OVF_LSB = 12;

  localparam logic [15:0] OVF_UP_FROM   = 16'hFFFE;
  localparam logic [15:0] OVF_DOWN_FROM = 16'h0001;
  localparam logic [15:0] CNT_RESET     = 16'h0000;

  // compare actions; in capture mode the same field selects edges
  localparam logic [1:0] ACT_NONE   = 2'h0;
  localparam logic [1:0] ACT_SET    = 2'h1;
  localparam logic [1:0] ACT_CLEAR  = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;

  typedef struct packed {
    logic cascadeDirFromFirst;
    logic cascade;
    logic quadrature;
    logic extDirection;
    logic extClock;
    logic countUp;
    logic enable;
  } eta_timer_ctl_type;

  typedef struct packed {
    logic       startConversion;
    logic       resetOther;
    logic       resetOwn;
    logic [1:0] action;
    logic       reenable;
    logic       compareMode;
    logic       timerSel;
    logic       overwrite;
  } eta_chan_ctl_type;

  localparam int TCTL_W = $bits(eta_timer_ctl_type);
  localparam int CCTL_W = $bits(eta_chan_ctl_type);
  localparam logic [TCTL_W-1:0] TCTL_RESET = 7'h00;
  localparam logic [CCTL_W-1:0] CCTL_RESET = 9'h000;
endpackage : eta_pkg

// ===== eta_event_timer.sv
// two up/down counters with ten capture/compare and two compare-only channels
`timescale 1ns/1ps

module eta_event_timer (
  // clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        rst,
  // register bus
  input  wire logic [eta_pkg::ADDR_W-1:0]  avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [31:0]                 avs_writedata,
  input  wire logic [3:0]                  avs_byteenable,
  output logic [31:0]                      avs_readdata,
  output logic                             avs_waitrequest,
  // counter pins
  input  wire logic [1:0]                  counterExtClockPin,
  input  wire logic [1:0]                  counterExtDirectionPin,
  // channel pins
  input  wire logic [9:0]                  chPinIn,
  output logic [9:0]                       chPinOut,
  output logic [9:0]                       chPinOe,
  // events to the rest of the chip
  output logic                             conversionStart,
  output logic                             overrunIrq
);
  typedef struct packed {
    logic                                          phase;
    logic [1:0][15:0]                              cnt;
    logic [1:0]                                    changed;
    logic [1:0][eta_pkg::TCTL_W-1:0]               tctl;
    logic [1:0][1:0]                               qPrev;
    logic [1:0][1:0]                               qCur;
    logic [9:0]                                    chPrev;
    logic [eta_pkg::NUM_CH-1:0][eta_pkg::CCTL_W-1:0] chCtl;
    logic [eta_pkg::NUM_CH-1:0][15:0]              chTime;
    logic [9:0][15:0]                              capBuf;
    logic [9:0]                                    bufFull;
    logic [9:0]                                    timeFull;
    logic [eta_pkg::NUM_CH-1:0]                    armed;
    logic [eta_pkg::NUM_CH-1:0]                    chPend;
    logic [1:0]                                    ovfPend;
    logic [9:0]                                    ovrPend;
    logic [9:0]                                    ovrMask;
    logic [9:0]                                    pinOut;
    logic [9:0]                                    pinOe;
    logic                                          convStart;
    logic                                          ovrIrq;
    logic                                          waitReq;
    logic [31:0]                                   readData;
  } eta_state_type;

  eta_state_type                 s;
  eta_state_type                 next_s;
  eta_pkg::eta_timer_ctl_type    tc;
  eta_pkg::eta_chan_ctl_type     cc;
  logic                          accept;
  logic                          rdEn;
  logic                          wrEn;
  logic [7:0]                    wordAdr;
  logic [3:0]                    chIdx;
  logic [31:0]                   rdVal;
  logic [1:0]                    ovfEv;
  logic [1:0]                    dirEff;
  logic [1:0]                    rstReq;
  logic                          stepEn;
  logic                          stepUp;
  logic                          xNow;
  logic                          xOld;
  logic                          yNow;
  logic                          yOld;
  logic                          inc;
  logic                          dec;
  logic                          edgeHit;
  logic [15:0]                   selCnt;
  logic [3:0]                    pinIdx;

  always_comb begin
    next_s  = s;
    tc      = '0;
    cc      = '0;
    ovfEv   = '0;
    dirEff  = '0;
    rstReq  = '0;
    stepEn  = 1'b0;
    stepUp  = 1'b0;
    xNow    = 1'b0;
    xOld    = 1'b0;
    yNow    = 1'b0;
    yOld    = 1'b0;
    inc     = 1'b0;
    dec     = 1'b0;
    edgeHit = 1'b0;
    selCnt  = '0;
    pinIdx  = '0;
    rdVal   = '0;
    next_s.phase     = ~s.phase;
    next_s.changed   = '0;
    next_s.convStart = 1'b0;
    next_s.waitReq   = 1'b1;
    next_s.chPrev    = chPinIn;

    // bus: one wait cycle, then a single answer cycle
    accept  = (avs_read | avs_write) & s.waitReq;
    rdEn    = accept & avs_read;
    wrEn    = accept & avs_write & (|avs_byteenable);
    wordAdr = avs_address & eta_pkg::ADR_BLK_MASK;
    chIdx   = 4'(avs_address[5:2]);
    if (accept) begin
      next_s.waitReq = 1'b0;
    end
    unique case (wordAdr)
      eta_pkg::ADR_CH_CTL: begin
        if (chIdx < 4'(eta_pkg::NUM_CH)) begin
          rdVal = 32'(s.chCtl[chIdx]);
        end
      end
      eta_pkg::ADR_CH_TIME: begin
        if (chIdx < 4'(eta_pkg::NUM_CH)) begin
          rdVal = 32'(s.chTime[chIdx]);
        end
      end
      8'h00: begin
        unique case (avs_address)
          eta_pkg::ADR_TMR_CTL0: rdVal = 32'(s.tctl[0]);
          eta_pkg::ADR_TMR_CTL1: rdVal = 32'(s.tctl[1]);
          eta_pkg::ADR_TMR_VAL0: rdVal = 32'(s.cnt[0]);
          eta_pkg::ADR_TMR_VAL1: rdVal = 32'(s.cnt[1]);
          eta_pkg::ADR_PEND:     rdVal = 32'({s.ovfPend, s.chPend});
          eta_pkg::ADR_OVR_PEND: rdVal = 32'(s.ovrPend);
          eta_pkg::ADR_OVR_MASK: rdVal = 32'(s.ovrMask);
          default:               rdVal = '0;
        endcase
      end
      default: rdVal = '0;
    endcase
    if (rdEn) begin
      next_s.readData = rdVal;
    end

    // read of a capture time register pulls the buffer up
    if (rdEn && wordAdr == eta_pkg::ADR_CH_TIME && chIdx < 4'(eta_pkg::NUM_CAP)) begin
      if (s.bufFull[chIdx]) begin
        next_s.chTime[chIdx]  = s.capBuf[chIdx];
        next_s.bufFull[chIdx] = 1'b0;
        next_s.chPend[chIdx]  = 1'b1;
      end else begin
        next_s.timeFull[chIdx] = 1'b0;
      end
    end

    // register writes, pending bits write-one-to-clear, before any hardware set so the set wins
    if (wrEn) begin
      unique case (wordAdr)
        eta_pkg::ADR_CH_CTL: begin
          if (chIdx < 4'(eta_pkg::NUM_CH)) begin
            next_s.chCtl[chIdx] = avs_writedata[eta_pkg::CCTL_W-1:0];
          end
        end
        eta_pkg::ADR_CH_TIME: begin
          if (chIdx < 4'(eta_pkg::NUM_CH)) begin
            next_s.chTime[chIdx] = avs_writedata[15:0];
            next_s.armed[chIdx]  = 1'b1;
          end
        end
        8'h00: begin
          unique case (avs_address)
            eta_pkg::ADR_TMR_CTL0: next_s.tctl[0] = avs_writedata[eta_pkg::TCTL_W-1:0];
            eta_pkg::ADR_TMR_CTL1: next_s.tctl[1] = avs_writedata[eta_pkg::TCTL_W-1:0];
            eta_pkg::ADR_PEND: begin
              next_s.chPend  = s.chPend & ~avs_writedata[eta_pkg::NUM_CH-1:0];
              next_s.ovfPend = s.ovfPend & ~avs_writedata[eta_pkg::PEND_OVF_LSB +: 2];
            end
            eta_pkg::ADR_OVR_PEND: next_s.ovrPend = s.ovrPend & ~avs_writedata[9:0];
            eta_pkg::ADR_OVR_MASK: next_s.ovrMask = avs_writedata[9:0];
            default: ;
          endcase
        end
        default: ;
      endcase
    end

    // channels act on the count as it stands this cycle
    for (int i = 0; i < eta_pkg::NUM_CH; i++) begin
      cc     = eta_pkg::eta_chan_ctl_type'(s.chCtl[i]);
      selCnt = s.cnt[cc.timerSel];
      pinIdx = (i >= eta_pkg::NUM_CAP) ? 4'(i - 2) : 4'(i);
      if (cc.compareMode || i >= eta_pkg::NUM_CAP) begin
        if (s.changed[cc.timerSel] && s.armed[i] && selCnt == s.chTime[i]) begin
          next_s.armed[i]  = cc.reenable;
          next_s.chPend[i] = 1'b1;
          if (cc.startConversion) begin
            next_s.convStart = 1'b1;
          end
          if (cc.resetOwn) begin
            rstReq[cc.timerSel] = 1'b1;
          end
          if (cc.resetOther) begin
            rstReq[~cc.timerSel] = 1'b1;
          end
          unique case (cc.action)
            eta_pkg::ACT_SET:    next_s.pinOut[pinIdx] = 1'b1;
            eta_pkg::ACT_CLEAR:  next_s.pinOut[pinIdx] = 1'b0;
            eta_pkg::ACT_TOGGLE: next_s.pinOut[pinIdx] = ~next_s.pinOut[pinIdx];
            eta_pkg::ACT_NONE:   ;
          endcase
        end
      end else begin
        edgeHit = (cc.action[0] & ~s.chPrev[i] & chPinIn[i])
                | (cc.action[1] & s.chPrev[i] & ~chPinIn[i]);
        if (edgeHit) begin
          if (!next_s.timeFull[i]) begin
            next_s.chTime[i]   = selCnt;
            next_s.timeFull[i] = 1'b1;
            next_s.chPend[i]   = 1'b1;
          end else if (!next_s.bufFull[i]) begin
            next_s.capBuf[i]  = selCnt;
            next_s.bufFull[i] = 1'b1;
          end else begin
            next_s.ovrPend[i] = 1'b1;
            if (cc.overwrite) begin
              next_s.capBuf[i] = selCnt;
            end
          end
          if (!(next_s.timeFull[i] && s.bufFull[i] && !cc.overwrite && s.timeFull[i])) begin
            if (cc.startConversion) begin
              next_s.convStart = 1'b1;
            end
            if (cc.resetOther) begin
              rstReq[~cc.timerSel] = 1'b1;
            end
          end
        end
      end
    end

    // counters: pins sampled on phase one, stepping on phase two
    for (int t = 0; t < eta_pkg::NUM_TMR; t++) begin
      tc   = eta_pkg::eta_timer_ctl_type'(s.tctl[t]);
      xNow = s.qCur[t][0];
      xOld = s.qPrev[t][0];
      yNow = s.qCur[t][1];
      yOld = s.qPrev[t][1];
      dirEff[t] = tc.extDirection ? yNow : tc.countUp;
      if (!s.phase) begin
        next_s.qPrev[t] = s.qCur[t];
        next_s.qCur[t]  = {counterExtDirectionPin[t], counterExtClockPin[t]};
        stepEn = 1'b0;
      end else if (tc.quadrature) begin
        dec = (xOld & ~xNow & ~yNow) | (~xOld & xNow & yNow)
            | (~yOld & yNow & ~xNow) | (yOld & ~yNow & xNow);
        inc = (~xOld & xNow & ~yNow) | (xOld & ~xNow & yNow)
            | (~yOld & yNow & xNow) | (yOld & ~yNow & ~xNow);
        stepEn = inc | dec;
        stepUp = inc;
      end else if (t == 1 && tc.cascade) begin
        stepEn = ovfEv[0];
        stepUp = tc.cascadeDirFromFirst ? dirEff[0] : tc.countUp;
      end else begin
        stepEn = tc.extClock ? (~xOld & xNow) : 1'b1;
        stepUp = dirEff[t];
      end
      stepEn = stepEn & tc.enable & s.phase;
      if (rstReq[t]) begin
        next_s.cnt[t]     = eta_pkg::CNT_RESET;
        next_s.changed[t] = 1'b1;
      end else if (stepEn) begin
        next_s.cnt[t]     = stepUp ? s.cnt[t] + 16'h0001 : s.cnt[t] - 16'h0001;
        next_s.changed[t] = 1'b1;
        if ((stepUp && s.cnt[t] == eta_pkg::OVF_UP_FROM)
            || (!stepUp && s.cnt[t] == eta_pkg::OVF_DOWN_FROM)) begin
          next_s.ovfPend[t] = 1'b1;
          ovfEv[t]          = 1'b1;
        end
      end
    end

    // counter value writes override stepping
    if (wrEn && avs_address == eta_pkg::ADR_TMR_VAL0) begin
      next_s.cnt[0] = avs_writedata[15:0];
    end
    if (wrEn && avs_address == eta_pkg::ADR_TMR_VAL1) begin
      next_s.cnt[1] = avs_writedata[15:0];
    end

    // pin drive: compare channel or its compare-only partner
    for (int p = 0; p < eta_pkg::NUM_CAP; p++) begin
      cc = eta_pkg::eta_chan_ctl_type'(next_s.chCtl[p]);
      next_s.pinOe[p] = cc.compareMode;
    end
    for (int k = eta_pkg::NUM_CAP; k < eta_pkg::NUM_CH; k++) begin
      cc = eta_pkg::eta_chan_ctl_type'(next_s.chCtl[k]);
      if (cc.action != eta_pkg::ACT_NONE) begin
        next_s.pinOe[k - 2] = 1'b1;
      end
    end
    next_s.ovrIrq = |(next_s.ovrPend & next_s.ovrMask);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s         <= '0;
      s.waitReq <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign avs_readdata    = s.readData;
  assign avs_waitrequest = s.waitReq;
  assign chPinOut        = s.pinOut;
  assign chPinOe         = s.pinOe;
  assign conversionStart = s.convStart;
  assign overrunIrq      = s.ovrIrq;
endmodule : eta_event_timer

// ===== eta_event_timer_props.sv
// port assertions for the event timer array
`timescale 1ns/1ps
module eta_event_timer_props (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst,
  // register bus
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // pins and events
  input wire logic [9:0]  chPinIn,
  input wire logic [9:0]  chPinOut,
  input wire logic [9:0]  chPinOe,
  input wire logic        conversionStart,
  input wire logic        overrunIrq
);
  logic [3:0] wrAge;
  logic [3:0] pinAge;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  // cycles since the last write request or capture pin change
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wrAge  <= 4'hF;
      pinAge <= 4'hF;
    end else begin
      wrAge  <= avs_write ? 4'h0 : ((wrAge == 4'hF) ? wrAge : wrAge + 4'h1);
      pinAge <= $changed(chPinIn) ? 4'h0 : ((pinAge == 4'hF) ? pinAge : pinAge + 4'h1);
    end
  end

  bus_answer_a: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered in one cycle");
  answer_once_a: assert property (
    !avs_waitrequest |=> avs_waitrequest)
    else $error("answer held longer than one cycle");
  answer_cause_a: assert property (
    $fell(avs_waitrequest) |-> $past(avs_read || avs_write))
    else $error("answer without a request");
  reset_quiet_a: assert property (
    $fell(rst) |-> chPinOut == 10'h000 && chPinOe == 10'h000 && !conversionStart
      && !overrunIrq && avs_waitrequest)
    else $error("outputs not quiet after reset");
  read_hold_a: assert property (
    !avs_read |=> $stable(avs_readdata))
    else $error("read data moved without a read");
  irq_rise_a: assert property (
    $rose(overrunIrq) |-> pinAge < 4'h8 || wrAge < 4'h4)
    else $error("overrun request rose without cause");
  irq_fall_a: assert property (
    $fell(overrunIrq) |-> wrAge < 4'h4)
    else $error("overrun request fell without a write");
  oe_cause_a: assert property (
    $changed(chPinOe) |-> wrAge < 4'h4)
    else $error("pin enable changed without a write");
  pin_idle_a: assert property (
    ((chPinOut ^ $past(chPinOut)) & ~$past(chPinOe)) != 10'h000 |-> wrAge < 4'h4)
    else $error("pin moved outside compare mode");
endmodule : eta_event_timer_props

bind eta_event_timer eta_event_timer_props u_props (
  .sys_clk(sys_clk), .rst(rst), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .chPinIn(chPinIn),
  .chPinOut(chPinOut), .chPinOe(chPinOe), .conversionStart(conversionStart),
  .overrunIrq(overrunIrq));

// ===== eta_pin_source.sv
// encoder phases and capture event source
`timescale 1ns/1ps
module eta_pin_source (
  // clock
  input  wire logic sys_clk,
  // encoder phases and capture pins
  output logic [1:0] phaseX,
  output logic [1:0] phaseY,
  output logic [9:0] capPin
);
  initial begin
    phaseX = 2'b00;
    phaseY = 2'b00;
    capPin = 10'h000;
  end

  // one gray step forward or back, then held
  task automatic quad(input int t, input logic up);
    if (up == (phaseX[t] == phaseY[t])) begin
      phaseX[t] <= ~phaseX[t];
    end else begin
      phaseY[t] <= ~phaseY[t];
    end
    repeat (4) @(posedge sys_clk);
  endtask : quad

  task automatic pulse(input int ch);
    capPin[ch] <= 1'b1;
    repeat (4) @(posedge sys_clk);
    capPin[ch] <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask : pulse
endmodule : eta_pin_source

// ===== tb.sv
// self-checking bench for the event timer array
`timescale 1ns/1ps
module tb;
  logic        sys_clk;
  logic        rst;
  logic [7:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [1:0]  extClk;
  logic [1:0]  extDir;
  logic [9:0]  capPin;
  logic [9:0]  chPinOut;
  logic [9:0]  chPinOe;
  logic        conversionStart;
  logic        overrunIrq;
  logic [31:0] seed;
  logic [31:0] rd;
  logic [31:0] r;
  logic [31:0] v0;
  logic [15:0] tv [3];
  logic [1:0]  mode;
  logic [7:0]  chOff;
  int          badCount;
  int          checks;
  int          cycles;
  int          convCount;
  int          ch;
  int          nu;
  int          nd;
  localparam logic [15:0] OVF_START [4] = '{16'hFFFD, 16'h0003, 16'h0000, 16'h0000};

  eta_event_timer uut (
    .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .counterExtClockPin(extClk), .counterExtDirectionPin(extDir), .chPinIn(capPin),
    .chPinOut(chPinOut), .chPinOe(chPinOe), .conversionStart(conversionStart),
    .overrunIrq(overrunIrq));
  eta_pin_source src (.sys_clk(sys_clk), .phaseX(extClk), .phaseY(extDir), .capPin(capPin));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // counter value after a number of up and down steps
  function automatic logic [31:0] expCount(input logic [15:0] start, input int up, input int down);
    return {16'h0000, start + 16'(up) - 16'(down)};
  endfunction : expCount

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      badCount++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task endOfTest();
    if (badCount == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : endOfTest

  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge sys_clk);
  endtask : bus

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wreg

  task automatic rreg(input logic [7:0] a);
    bus(1'b0, a, 32'h0000_0000);
  endtask : rreg

  always @(posedge sys_clk) begin
    cycles++;
    if (conversionStart === 1'b1) convCount++;
    if (cycles == 6000) begin
      badCount++;
      endOfTest();
    end
  end

  initial begin
    rst = 1'b1;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    seed = 32'h0000_904f;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    wreg(eta_pkg::ADR_TMR_CTL0, 32'h0000_0003);
    repeat (100) @(posedge sys_clk);
    wreg(eta_pkg::ADR_TMR_CTL0, 32'h0000_0000);
    rreg(eta_pkg::ADR_TMR_VAL0);
    v0 = rd;
    check("countRate", rd >= 32'd45 && rd <= 32'd56, 1'b1);
    repeat (20) @(posedge sys_clk);
    rreg(eta_pkg::ADR_TMR_VAL0);
    check("countHold", rd, v0);
    for (int i = 0; i < 4; i++) begin
      wreg(eta_pkg::ADR_PEND, 32'h0000_3FFF);
      wreg(eta_pkg::ADR_TMR_VAL0, {16'h0000, OVF_START[i]});
      wreg(eta_pkg::ADR_TMR_CTL0, {30'h0, !i[0], 1'b1});
      repeat (20) @(posedge sys_clk);
      wreg(eta_pkg::ADR_TMR_CTL0, 32'h0000_0000);
      rreg(eta_pkg::ADR_PEND);
      check("ovfFlag", rd[eta_pkg::PEND_OVF_LSB], i < 2);
    end
    r = rnd();
    nu = int'(r[2:0]) + 1;
    nd = int'(r[4:3]);
    wreg(eta_pkg::ADR_TMR_CTL1, 32'h0000_0011);
    wreg(eta_pkg::ADR_TMR_VAL1, 32'h0000_0100);
    repeat (nu) src.quad(1, 1'b1);
    repeat (nd) src.quad(1, 1'b0);
    rreg(eta_pkg::ADR_TMR_VAL1);
    check("quadCount", rd, expCount(16'h0100, nu, nd));
    wreg(eta_pkg::ADR_TMR_CTL1, 32'h0000_0000);
    src.quad(1, 1'b1);
    rreg(eta_pkg::ADR_TMR_VAL1);
    check("quadHold", rd, expCount(16'h0100, nu, nd));
    // cascade: one overflow of the first counter, direction from it or own bit
    for (int dn = 0; dn < 2; dn++) begin
      wreg(eta_pkg::ADR_TMR_VAL1, 32'h0000_0010);
      wreg(eta_pkg::ADR_TMR_VAL0, 32'h0000_FFFD);
      wreg(eta_pkg::ADR_TMR_CTL1, (dn == 1) ? 32'h0000_0021 : 32'h0000_0061);
      wreg(eta_pkg::ADR_TMR_CTL0, 32'h0000_0003);
      repeat (20) @(posedge sys_clk);
      wreg(eta_pkg::ADR_TMR_CTL0, 32'h0000_0000);
      rreg(eta_pkg::ADR_TMR_VAL1);
      check("cascadeCount", rd, expCount(16'h0010, 1 - dn, dn));
    end
    wreg(eta_pkg::ADR_TMR_CTL1, 32'h0000_0000);
    for (int ow = 0; ow < 2; ow++) begin
      r = rnd();
      ch = int'(r % 10);
      chOff = 8'(ch * 4);
      mode = r[8] ? 2'h1 : 2'h2;
      for (int k = 0; k < 3; k++) begin
        r = rnd();
        tv[k] = r[15:0];
      end
      // second and third times must differ for the overwrite check
      tv[2] = ~tv[1];
      wreg(eta_pkg::ADR_PEND, 32'h0000_3FFF);
      wreg(eta_pkg::ADR_OVR_PEND, 32'h0000_03FF);
      wreg(eta_pkg::ADR_CH_CTL + chOff, {26'h0, mode, 3'h0, ow[0]});
      for (int k = 0; k < 3; k++) begin
        wreg(eta_pkg::ADR_TMR_VAL0, {16'h0000, tv[k]});
        src.pulse(ch);
        rreg(eta_pkg::ADR_PEND);
        check("eventFlag", rd[ch], k == 0);
        if (k == 0) wreg(eta_pkg::ADR_PEND, 32'h1 << ch);
      end
      rreg(eta_pkg::ADR_OVR_PEND);
      check("overrunFlag", rd[ch], 1'b1);
      wreg(eta_pkg::ADR_OVR_MASK, 32'h1 << ch);
      check("irqOn", overrunIrq, 1'b1);
      rreg(eta_pkg::ADR_CH_TIME + chOff);
      check("firstTime", rd, {16'h0000, tv[0]});
      rreg(eta_pkg::ADR_PEND);
      check("refillFlag", rd[ch], 1'b1);
      rreg(eta_pkg::ADR_CH_TIME + chOff);
      check("secondTime", rd, {16'h0000, (ow == 1) ? tv[2] : tv[1]});
      wreg(eta_pkg::ADR_OVR_PEND, 32'h0000_03FF);
      check("irqOff", overrunIrq, 1'b0);
    end
    wreg(eta_pkg::ADR_PEND, 32'h0000_3FFF);
    wreg(eta_pkg::ADR_TMR_VAL0, 32'h0000_0200);
    wreg(eta_pkg::ADR_CH_CTL + 8'h28, 32'h0000_0154);
    wreg(eta_pkg::ADR_CH_TIME + 8'h28, 32'h0000_0208);
    convCount = 0;
    wreg(eta_pkg::ADR_TMR_CTL0, 32'h0000_0003);
    repeat (60) @(posedge sys_clk);
    wreg(eta_pkg::ADR_TMR_CTL0, 32'h0000_0000);
    check("sharedPin", chPinOut[8], 1'b1);
    check("sharedOe", chPinOe[8], 1'b1);
    check("convOnce", convCount, 1);
    rreg(eta_pkg::ADR_TMR_VAL0);
    check("ownReset", rd < 32'h0000_0040, 1'b1);
    rreg(eta_pkg::ADR_PEND);
    check("matchFlag", rd[10], 1'b1);
    endOfTest();
  end
endmodule : tb
